// *** verilog/chg_link_consts.svh ***
// Constants shared by both ends of the charger two-wire register link
`ifndef CHG_LINK_CONSTS_SVH
`define CHG_LINK_CONSTS_SVH

`define SLAVE_ADDR      7'h0A
`define DIR_READ        1'b1
`define DIR_WRITE       1'b0
`define BYTE_BITS       4'h8
`define CLK_PERIOD_NS   10
`define SCL_PERIOD_NS   2500
`define SCL_HALF_CYCLES \
	((`SCL_PERIOD_NS + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS))
`define WR_FIFO_DEPTH   4
`define WR_WORD_WIDTH   16
`define ACK_LEVEL       1'b0
`define NAK_LEVEL       1'b1

`endif

// *** verilog/chg_link_pkg.sv ***
// Types shared by both ends of the charger two-wire register link
package chg_link_pkg;

	typedef enum logic [3:0] {
		SL_IDLE,
		SL_ADDR,
		SL_ADDR_ACK,
		SL_REG,
		SL_REG_CHK,
		SL_REG_ACK,
		SL_WDATA,
		SL_WSTALL,
		SL_WDATA_ACK,
		SL_RDATA,
		SL_RDATA_ACK
	} slave_state_t;

	typedef enum logic [1:0] {
		MS_IDLE,
		MS_START,
		MS_BIT,
		MS_STOP
	} master_state_t;

	typedef enum logic [2:0] {
		STEP_ADDRW,
		STEP_REG,
		STEP_WDATA,
		STEP_ADDRR,
		STEP_RDATA
	} master_step_t;

	typedef struct packed {
		slave_state_t state;
		logic [3:0]   nbit;
		logic [7:0]   shreg;
		logic [7:0]   ptr;
		logic         is_read;
		logic         sda_oe;
		logic         scl_oe;
		logic         scl_s1;
		logic         scl_s2;
		logic         scl_q;
		logic         sda_s1;
		logic         sda_s2;
		logic         sda_q;
	} slave_regs_t;

	typedef struct packed {
		master_state_t state;
		master_step_t  step;
		logic [1:0]    sub;
		logic          ph;
		logic [7:0]    cnt;
		logic [3:0]    nbit;
		logic [8:0]    tx;
		logic [8:0]    rx;
		logic [7:0]    left;
		logic          rd;
		logic [7:0]    reg_a;
		logic          scl_oe;
		logic          sda_oe;
		logic          tx_take;
		logic          rx_valid;
		logic [7:0]    rx_data;
		logic          done;
		logic          nak_err;
		logic          scl_s1;
		logic          scl_s2;
		logic          sda_s1;
		logic          sda_s2;
	} master_regs_t;

endpackage

// *** verilog/chg_link_if.sv ***
// Open-drain two-wire link joining the bus master and the charger slave
`timescale 1ns/1ns
interface chg_link_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_scl_out;
	logic s_scl_oe;
	logic s_sda_out;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups hold both lines high unless someone drives a low
	assign scl = ~((m_scl_oe & ~m_scl_out) | (s_scl_oe & ~s_scl_out));
	assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

	modport master (
		output m_scl_out,
		output m_scl_oe,
		output m_sda_out,
		output m_sda_oe,
		input  scl,
		input  sda
	);

	modport slave (
		output s_scl_out,
		output s_scl_oe,
		output s_sda_out,
		output s_sda_oe,
		input  scl,
		input  sda
	);
endinterface

// *** verilog/chg_slave.sv ***
// Charger register slave end of the two-wire link, with its write FIFO
// Behaviour
// - Answer only slave address 0x0A after START
// - Address LSB one reads, zero writes
// - Work with serial clock up to 400kHz
// - Sample each data bit on clock rise
// - Data edge while clock high is control
// - Both lines released high when bus idle
// - Acknowledge own address on ninth clock
// - ACK valid register address, NAK invalid
// - Single write: S, addr, reg, data, P
// - Burst write stores, acks, increments pointer
// - Single read: Sr, read address, data, NAK
// - Burst read continues while master acknowledges
// - Master ends with STOP or repeated START
// - ACK holds data low through ninth high
// - NAK leaves data high through ninth clock
`timescale 1ns/1ns
`include "chg_link_consts.svh"

////////////////////////////////////////////////////////////////////////////
module chg_wr_fifo #(
	parameter int WIDTH = `WR_WORD_WIDTH,
	parameter int DEPTH = `WR_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 count;
	} fifo_regs_t;

	fifo_regs_t r;
	fifo_regs_t next_r;
	logic       do_push;
	logic       do_pop;

	assign in_ready  = r.count != (AW+1)'(DEPTH);
	assign out_valid = r.count != '0;
	assign out_data  = r.mem[r.rp];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	always_comb begin
		next_r = r;
		if (do_push) begin
			next_r.mem[r.wp] = in_data;
			next_r.wp        = r.wp + 1'b1;
		end
		if (do_pop) begin
			next_r.rp = r.rp + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_r.count = r.count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_r.count = r.count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r <= '0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end
endmodule // chg_wr_fifo

////////////////////////////////////////////////////////////////////////////
module chg_slave (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	chg_link_if.slave       link,
	output logic      [7:0] reg_ptr,
	input  wire logic       reg_ptr_ok,
	input  wire logic [7:0] rd_data,
	output logic            wr_valid,
	input  wire logic       wr_ready,
	output logic      [7:0] wr_addr,
	output logic      [7:0] wr_data
);
	chg_link_pkg::slave_regs_t r;
	chg_link_pkg::slave_regs_t next_r;
	logic                      rise;
	logic                      fall;
	logic                      start_seen;
	logic                      stop_seen;
	logic                      push;
	logic                      fifo_ready;
	logic [15:0]               fifo_out;

	// Open-drain: drive only lows
	assign link.s_sda_out = 1'b0;
	assign link.s_scl_out = 1'b0;
	assign link.s_sda_oe  = r.sda_oe;
	assign link.s_scl_oe  = r.scl_oe;
	assign reg_ptr        = r.ptr;
	assign wr_addr        = fifo_out[15:8];
	assign wr_data        = fifo_out[7:0];

	assign rise       = r.scl_s2 & ~r.scl_q;
	assign fall       = ~r.scl_s2 & r.scl_q;
	assign start_seen = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
	assign stop_seen  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;

	chg_wr_fifo #(
		.WIDTH (`WR_WORD_WIDTH),
		.DEPTH (`WR_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   ({r.ptr, r.shreg}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (fifo_out)
	);

	always_comb begin
		next_r        = r;
		push          = 1'b0;
		next_r.scl_s1 = link.scl;
		next_r.scl_s2 = r.scl_s1;
		next_r.scl_q  = r.scl_s2;
		next_r.sda_s1 = link.sda;
		next_r.sda_s2 = r.sda_s1;
		next_r.sda_q  = r.sda_s2;
		if (start_seen) begin
			// Repeated START restarts address matching mid-frame
			next_r.state  = chg_link_pkg::SL_ADDR;
			next_r.nbit   = '0;
			next_r.sda_oe = 1'b0;
			next_r.scl_oe = 1'b0;
		end else if (stop_seen) begin
			next_r.state  = chg_link_pkg::SL_IDLE;
			next_r.sda_oe = 1'b0;
			next_r.scl_oe = 1'b0;
		end else begin
			case (r.state)
			chg_link_pkg::SL_IDLE: begin
				next_r.sda_oe = 1'b0;
				next_r.scl_oe = 1'b0;
			end
			chg_link_pkg::SL_ADDR,
			chg_link_pkg::SL_REG,
			chg_link_pkg::SL_WDATA: begin
				if (rise) begin
					next_r.shreg = {r.shreg[6:0], r.sda_s2};
					next_r.nbit  = r.nbit + 1'b1;
				end
				if (fall && r.nbit == `BYTE_BITS) begin
					next_r.nbit = '0;
					if (r.state == chg_link_pkg::SL_ADDR) begin
						if (r.shreg[7:1] == `SLAVE_ADDR) begin
							next_r.is_read = r.shreg[0] == `DIR_READ;
							next_r.sda_oe  = 1'b1;
							next_r.state   = chg_link_pkg::SL_ADDR_ACK;
						end else begin
							next_r.state = chg_link_pkg::SL_IDLE;
						end
					end else if (r.state == chg_link_pkg::SL_REG) begin
						next_r.ptr   = r.shreg;
						next_r.state = chg_link_pkg::SL_REG_CHK;
					end else if (fifo_ready) begin
						push          = 1'b1;
						next_r.sda_oe = 1'b1;
						next_r.state  = chg_link_pkg::SL_WDATA_ACK;
					end else begin
						// Full FIFO: stretch the clock rather than drop a byte
						next_r.scl_oe = 1'b1;
						next_r.state  = chg_link_pkg::SL_WSTALL;
					end
				end
			end
			chg_link_pkg::SL_WSTALL: begin
				if (fifo_ready) begin
					// Clock stays held until the ACK is already on the line
					push          = 1'b1;
					next_r.sda_oe = 1'b1;
					next_r.state  = chg_link_pkg::SL_WDATA_ACK;
				end
			end
			chg_link_pkg::SL_ADDR_ACK: begin
				if (fall) begin
					next_r.nbit = '0;
					if (r.is_read) begin
						next_r.shreg  = rd_data;
						next_r.sda_oe = ~rd_data[7];
						next_r.state  = chg_link_pkg::SL_RDATA;
					end else begin
						next_r.sda_oe = 1'b0;
						next_r.state  = chg_link_pkg::SL_REG;
					end
				end
			end
			chg_link_pkg::SL_REG_CHK: begin
				// Pointer is settled for one cycle before validity is judged
				next_r.sda_oe = reg_ptr_ok;
				next_r.state  = chg_link_pkg::SL_REG_ACK;
			end
			chg_link_pkg::SL_REG_ACK: begin
				if (fall) begin
					next_r.sda_oe = 1'b0;
					next_r.state  = r.sda_oe ? chg_link_pkg::SL_WDATA
						: chg_link_pkg::SL_IDLE;
				end
			end
			chg_link_pkg::SL_WDATA_ACK: begin
				next_r.scl_oe = 1'b0;
				if (fall) begin
					next_r.sda_oe = 1'b0;
					next_r.ptr    = r.ptr + 1'b1;
					next_r.state  = chg_link_pkg::SL_WDATA;
				end
			end
			chg_link_pkg::SL_RDATA: begin
				if (rise) begin
					next_r.nbit = r.nbit + 1'b1;
				end
				if (fall) begin
					if (r.nbit == `BYTE_BITS) begin
						next_r.nbit   = '0;
						next_r.sda_oe = 1'b0;
						next_r.ptr    = r.ptr + 1'b1;
						next_r.state  = chg_link_pkg::SL_RDATA_ACK;
					end else begin
						next_r.shreg  = {r.shreg[6:0], 1'b0};
						next_r.sda_oe = ~r.shreg[6];
					end
				end
			end
			chg_link_pkg::SL_RDATA_ACK: begin
				if (rise) begin
					next_r.shreg[0] = r.sda_s2;
				end
				if (fall) begin
					if (r.shreg[0] == `ACK_LEVEL) begin
						next_r.shreg  = rd_data;
						next_r.sda_oe = ~rd_data[7];
						next_r.state  = chg_link_pkg::SL_RDATA;
					end else begin
						next_r.state = chg_link_pkg::SL_IDLE;
					end
				end
			end
			default: begin
				next_r.state = chg_link_pkg::SL_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r        <= '0;
			r.scl_s1 <= 1'b1;
			r.scl_s2 <= 1'b1;
			r.scl_q  <= 1'b1;
			r.sda_s1 <= 1'b1;
			r.sda_s2 <= 1'b1;
			r.sda_q  <= 1'b1;
		end else if (clk_en) begin
			r <= next_r;
		end
	end
endmodule // chg_slave

// *** verilog/chg_master.sv ***
// Host bus-master end of the two-wire charger register link
`timescale 1ns/1ns
`include "chg_link_consts.svh"
module chg_master (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	chg_link_if.master      link,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_read,
	input  wire logic [7:0] cmd_reg,
	input  wire logic [7:0] cmd_count,
	input  wire logic [7:0] tx_data,
	output logic            tx_take,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            done,
	output logic            nak_err
);
	localparam logic [7:0] HALF_LAST = 8'(`SCL_HALF_CYCLES - 1);

	chg_link_pkg::master_regs_t r;
	chg_link_pkg::master_regs_t next_r;
	logic                       half_done;
	logic                       ack_in;

	assign link.m_scl_out = 1'b0;
	assign link.m_sda_out = 1'b0;
	assign link.m_scl_oe  = r.scl_oe;
	assign link.m_sda_oe  = r.sda_oe;
	assign cmd_ready      = r.state == chg_link_pkg::MS_IDLE;
	assign tx_take        = r.tx_take;
	assign rx_valid       = r.rx_valid;
	assign rx_data        = r.rx_data;
	assign done           = r.done;
	assign nak_err        = r.nak_err;
	assign half_done      = r.cnt == HALF_LAST;
	assign ack_in         = r.rx[0] == `ACK_LEVEL;

	always_comb begin
		next_r          = r;
		next_r.tx_take  = 1'b0;
		next_r.rx_valid = 1'b0;
		next_r.done     = 1'b0;
		next_r.scl_s1   = link.scl;
		next_r.scl_s2   = r.scl_s1;
		next_r.sda_s1   = link.sda;
		next_r.sda_s2   = r.sda_s1;
		next_r.cnt      = r.cnt + 1'b1;
		case (r.state)
		chg_link_pkg::MS_IDLE: begin
			next_r.cnt    = '0;
			next_r.scl_oe = 1'b0;
			next_r.sda_oe = 1'b0;
			if (cmd_valid) begin
				next_r.state   = chg_link_pkg::MS_START;
				next_r.step    = chg_link_pkg::STEP_ADDRW;
				next_r.sub     = 2'h0;
				next_r.rd      = cmd_read;
				next_r.reg_a   = cmd_reg;
				next_r.left    = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
				next_r.nak_err = 1'b0;
			end
		end
		chg_link_pkg::MS_START: begin
			// Also serves as repeated START from a held-low clock
			case (r.sub)
			2'h0: begin
				next_r.sda_oe = 1'b0;
				if (half_done) begin
					next_r.cnt    = '0;
					next_r.scl_oe = 1'b0;
					next_r.sub    = 2'h1;
				end
			end
			2'h1: begin
				if (!r.scl_s2) begin
					next_r.cnt = '0;
				end else if (half_done) begin
					next_r.cnt    = '0;
					next_r.sda_oe = 1'b1;
					next_r.sub    = 2'h2;
				end
			end
			default: begin
				if (half_done) begin
					next_r.cnt    = '0;
					next_r.scl_oe = 1'b1;
					next_r.sub    = 2'h0;
					next_r.state  = chg_link_pkg::MS_BIT;
					next_r.ph     = 1'b0;
					next_r.nbit   = '0;
					next_r.tx     = (r.step == chg_link_pkg::STEP_ADDRR)
						? {`SLAVE_ADDR, `DIR_READ, 1'b1}
						: {`SLAVE_ADDR, `DIR_WRITE, 1'b1};
				end
			end
			endcase
		end
		chg_link_pkg::MS_BIT: begin
			if (!r.ph) begin
				next_r.sda_oe = ~r.tx[8];
				if (half_done) begin
					next_r.cnt    = '0;
					next_r.scl_oe = 1'b0;
					next_r.ph     = 1'b1;
				end
			end else if (!r.scl_s2) begin
				// Slave may be stretching; the high half starts when seen
				next_r.cnt = '0;
			end else begin
				if (r.cnt == 8'h00) begin
					next_r.rx = {r.rx[7:0], r.sda_s2};
				end
				if (half_done) begin
					next_r.cnt    = '0;
					next_r.scl_oe = 1'b1;
					next_r.ph     = 1'b0;
					next_r.tx     = {r.tx[7:0], 1'b1};
					next_r.nbit   = r.nbit + 1'b1;
					if (r.nbit == `BYTE_BITS) begin
						next_r.nbit = '0;
						case (r.step)
						chg_link_pkg::STEP_ADDRW: begin
							next_r.step = chg_link_pkg::STEP_REG;
							next_r.tx   = {r.reg_a, 1'b1};
						end
						chg_link_pkg::STEP_REG: begin
							if (r.rd) begin
								next_r.step  = chg_link_pkg::STEP_ADDRR;
								next_r.state = chg_link_pkg::MS_START;
								next_r.sub   = 2'h0;
							end else begin
								next_r.step    = chg_link_pkg::STEP_WDATA;
								next_r.tx      = {tx_data, 1'b1};
								next_r.tx_take = 1'b1;
							end
						end
						chg_link_pkg::STEP_WDATA: begin
							next_r.left = r.left - 1'b1;
							if (r.left != 8'h01) begin
								next_r.tx      = {tx_data, 1'b1};
								next_r.tx_take = 1'b1;
							end
						end
						chg_link_pkg::STEP_ADDRR: begin
							next_r.step = chg_link_pkg::STEP_RDATA;
							next_r.tx   = {8'hFF, (r.left == 8'h01)};
						end
						default: begin
							next_r.rx_valid = 1'b1;
							next_r.rx_data  = r.rx[8:1];
							next_r.left     = r.left - 1'b1;
							next_r.tx       = {8'hFF, (r.left == 8'h02)};
						end
						endcase
						// Address, register and write bytes need the slave's ACK
						if ((r.step != chg_link_pkg::STEP_RDATA) && !ack_in) begin
							next_r.nak_err = 1'b1;
							next_r.state   = chg_link_pkg::MS_STOP;
							next_r.sub     = 2'h0;
						end else if (r.left == 8'h01 &&
							(r.step == chg_link_pkg::STEP_WDATA ||
							r.step == chg_link_pkg::STEP_RDATA)) begin
							next_r.state = chg_link_pkg::MS_STOP;
							next_r.sub   = 2'h0;
						end
					end
				end
			end
		end
		chg_link_pkg::MS_STOP: begin
			case (r.sub)
			2'h0: begin
				next_r.sda_oe = 1'b1;
				if (half_done) begin
					next_r.cnt    = '0;
					next_r.scl_oe = 1'b0;
					next_r.sub    = 2'h1;
				end
			end
			2'h1: begin
				if (!r.scl_s2) begin
					next_r.cnt = '0;
				end else if (half_done) begin
					next_r.cnt    = '0;
					next_r.sda_oe = 1'b0;
					next_r.sub    = 2'h2;
				end
			end
			default: begin
				if (half_done) begin
					next_r.done  = 1'b1;
					next_r.state = chg_link_pkg::MS_IDLE;
					next_r.sub   = 2'h0;
				end
			end
			endcase
		end
		default: begin
			next_r.state = chg_link_pkg::MS_IDLE;
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r        <= '0;
			r.scl_s1 <= 1'b1;
			r.scl_s2 <= 1'b1;
			r.sda_s1 <= 1'b1;
			r.sda_s2 <= 1'b1;
		end else if (clk_en) begin
			r <= next_r;
		end
	end
endmodule // chg_master

// *** verification/chg_link_chk.sv ***
// Concurrent checks on the two-wire link between the master and the slave
`timescale 1ns/1ns
`include "chg_link_consts.svh"

module chg_link_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic s_scl_oe,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_d;
	logic       sda_d;
	logic [3:0] bitn;
	logic [3:0] byten;
	logic [7:0] shreg;
	logic       rd;
	logic [7:0] cnt;
	logic       start;
	logic       stop;
	logic       rise;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	assign start = scl & scl_d & sda_d & ~sda;
	assign stop  = scl & scl_d & ~sda_d & sda;
	assign rise  = scl & ~scl_d;

	////////////////////////////////////////////////////////////////////////
	// Bit and byte position on the wire; bitn is 9 during the ack clock
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			bitn  <= 4'h0;
			byten <= 4'h0;
			shreg <= 8'h00;
			rd    <= 1'b0;
			cnt   <= 8'h00;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			cnt   <= (scl != scl_d) ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
			if (start || stop) begin
				bitn  <= 4'h0;
				byten <= 4'h0;
			end else if (rise) begin
				bitn  <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
				byten <= byten + {3'h0, bitn == 4'h9};
				if (bitn != 4'h8) begin
					shreg <= {shreg[6:0], sda};
				end
				if (bitn == 4'h8 && byten == 4'h0) begin
					rd <= shreg[0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_idle_release;
		$rose(reset_n) |-> !m_scl_oe && !m_sda_oe && !s_scl_oe && !s_sda_oe;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("link not released after reset");

	property p_master_ctrl;
		scl && scl_d && $changed(m_sda_oe) |-> start || stop;
	endproperty
	a_master_ctrl: assert property (p_master_ctrl)
		else $error("master moved data while clock high");

	property p_slave_stable;
		scl && scl_d |-> $stable(s_sda_oe);
	endproperty
	a_slave_stable: assert property (p_slave_stable)
		else $error("slave moved data while clock high");

	property p_addr_ack;
		scl && scl_d && bitn == 4'h9 && byten == 4'h0 &&
			shreg[7:1] == `SLAVE_ADDR
			|-> !sda && s_sda_oe;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("own address not acknowledged");

	property p_slave_quiet;
		// The rising sample still shows the old bit count, so skip it
		scl && scl_d && bitn != 4'h9 && (byten == 4'h0 || !rd)
			|-> !s_sda_oe;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet)
		else $error("slave drove data in a write bit");

	property p_rd_ack;
		scl && scl_d && bitn == 4'h9 && byten != 4'h0 && rd |-> !s_sda_oe;
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("slave drove the master ack bit");

	property p_wr_ack;
		scl && scl_d && bitn == 4'h9 && byten != 4'h0 && !rd |-> !m_sda_oe;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("master drove the slave ack bit");

	property p_scl_period;
		scl != scl_d |-> cnt >= 8'd100;
	endproperty
	a_scl_period: assert property (p_scl_period)
		else $error("clock phase shorter than allowed");

	property p_stretch;
		$rose(s_scl_oe) |-> !scl_d;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("slave pulled clock low while high");

	c_start: cover property (start);
	c_stretch: cover property ($rose(s_scl_oe));
	c_burst_rd: cover property (scl && bitn == 4'h9 && byten == 4'h3 && rd);
endmodule // chg_link_chk

// *** verification/charger_i2c_register_slave_tb.sv ***
// Bench joining the bus master to the charger slave across the link
`timescale 1ns/1ns

module charger_i2c_register_slave_tb;
	typedef struct {
		logic       rd;
		logic [7:0] reg_a;
		logic [7:0] count;
		logic [7:0] d0;
		logic       nak;
	} row_t;

	// Probe half period, a little slower than the fastest legal clock
	localparam int HALF = 130;

	logic       clk;
	logic       reset_n;
	logic       run;
	logic       cmd_valid;
	logic       cmd_ready;
	logic       cmd_read;
	logic [7:0] cmd_reg;
	logic [7:0] cmd_count;
	logic [7:0] tx_data;
	logic       tx_take;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       done;
	logic       nak_err;
	logic [7:0] reg_ptr;
	logic [7:0] reg_ptr2;
	logic       wr_valid;
	logic       drain;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] regs [0:255];
	int         n_errors;
	int         samples_checked;
	int         n_tx;
	int         n_rx;
	row_t       rows [6];

	chg_link_if link ();
	chg_link_if link2 ();

	chg_master chg_master_i (.clk(clk), .reset_n(reset_n), .clk_en(run),
		.link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_count(cmd_count),
		.tx_data(tx_data), .tx_take(tx_take), .rx_valid(rx_valid),
		.rx_data(rx_data), .done(done), .nak_err(nak_err));

	// Registers 0x00 to 0x3F exist; anything above is refused
	chg_slave chg_slave_i (.clk(clk), .reset_n(reset_n), .clk_en(run),
		.link(link), .reg_ptr(reg_ptr), .reg_ptr_ok(reg_ptr < 8'h40),
		.rd_data(regs[reg_ptr]), .wr_valid(wr_valid), .wr_ready(drain),
		.wr_addr(wr_addr), .wr_data(wr_data));

	// Second slave faces a hand-driven master that may misaddress it
	chg_slave chg_slave_i2 (.clk(clk), .reset_n(reset_n), .clk_en(run),
		.link(link2), .reg_ptr(reg_ptr2), .reg_ptr_ok(reg_ptr2 < 8'h40),
		.rd_data(regs[reg_ptr2]), .wr_valid(), .wr_ready(drain),
		.wr_addr(), .wr_data());

	chg_link_chk chg_link_chk_i (.clk(clk), .reset_n(reset_n),
		.m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe),
		.s_scl_oe(link.s_scl_oe), .s_sda_oe(link.s_sda_oe),
		.scl(link.scl), .sda(link.sda));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (wr_valid && drain) begin
			regs[wr_addr] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Errors %0d in %0d checks", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic run_cmd(input row_t r);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_read = r.rd;
		cmd_reg = r.reg_a;
		cmd_count = r.count;
		tx_data = r.d0;
		n_tx = 0;
		n_rx = 0;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (int i = 0; i < 40000 && done !== 1'b1; i++) begin
			@(negedge clk);
			if (tx_take === 1'b1) begin
				n_tx++;
				tx_data = r.d0 + 8'(n_tx);
			end
			if (rx_valid === 1'b1) begin
				check(rx_data, r.d0 + 8'(n_rx));
				n_rx++;
			end
		end
		check({7'h00, done}, 8'h01);
		check({7'h00, nak_err}, {7'h00, r.nak});
	endtask

	// Hand-made transfer: one address byte, then STOP
	task automatic probe(input logic [7:0] b, input logic ack);
		link2.m_sda_oe = 1'b1;
		repeat (HALF) @(negedge clk);
		link2.m_scl_oe = 1'b1;
		for (int i = 0; i < 9; i++) begin
			link2.m_sda_oe = (i < 8) ? ~b[7 - i] : 1'b0;
			repeat (HALF) @(negedge clk);
			link2.m_scl_oe = 1'b0;
			repeat (HALF / 2) @(negedge clk);
			if (i == 8) begin
				check({7'h00, link2.sda}, {7'h00, ack});
			end
			repeat (HALF / 2) @(negedge clk);
			link2.m_scl_oe = 1'b1;
		end
		link2.m_sda_oe = 1'b1;
		repeat (HALF) @(negedge clk);
		link2.m_scl_oe = 1'b0;
		repeat (HALF) @(negedge clk);
		link2.m_sda_oe = 1'b0;
		repeat (HALF) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge clk);
		n_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		run = 1'b1;
		drain = 1'b1;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_reg = 8'h00;
		cmd_count = 8'h00;
		tx_data = 8'h00;
		link2.m_scl_out = 1'b0;
		link2.m_sda_out = 1'b0;
		link2.m_scl_oe = 1'b0;
		link2.m_sda_oe = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'h00;
		end
		rows[0] = '{1'b0, 8'h05, 8'h01, 8'h3C, 1'b0};
		rows[1] = '{1'b0, 8'h10, 8'h03, 8'hA0, 1'b0};
		rows[2] = '{1'b1, 8'h05, 8'h01, 8'h3C, 1'b0};
		rows[3] = '{1'b1, 8'h10, 8'h03, 8'hA0, 1'b0};
		rows[4] = '{1'b0, 8'h80, 8'h01, 8'h55, 1'b1};
		rows[5] = '{1'b1, 8'h90, 8'h01, 8'h00, 1'b1};
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		check({link.m_scl_oe, link.m_sda_oe, link.s_scl_oe, link.s_sda_oe,
			link.scl, link.sda, cmd_ready, wr_valid}, 8'h0E);
		check(reg_ptr, 8'h00);
		for (int k = 0; k < 6; k++) begin
			run_cmd(rows[k]);
			if (!rows[k].rd && !rows[k].nak) begin
				check(8'(n_tx), rows[k].count);
			end
			check(8'(n_rx), (rows[k].rd && !rows[k].nak) ?
				rows[k].count : 8'h00);
		end
		check(regs[8'h80], 8'h00);
		// Full write buffer must hold the clock low, not drop bytes
		drain = 1'b0;
		fork
			run_cmd('{1'b0, 8'h20, 8'h06, 8'hC0, 1'b0});
			begin
				for (int i = 0; i < 40000 && link.s_scl_oe !== 1'b1; i++) begin
					@(negedge clk);
				end
				check({6'h00, link.s_scl_oe, wr_valid}, 8'h03);
				repeat (500) @(negedge clk);
				drain = 1'b1;
			end
		join
		for (int i = 0; i < 6; i++) begin
			check(regs[8'h20 + i], 8'hC0 + 8'(i));
		end
		check({7'h00, wr_valid}, 8'h00);
		probe(8'h16, 1'b1);
		probe(8'h14, 1'b0);
		print_verdict();
	end
endmodule // charger_i2c_register_slave_tb
